/* src/prog_counter_paging_stack.v */
// Purpose: instruction pointer, page preselect and return stack
// Assumes: one op per instruction-clock edge from the decoder
// Notes: master_clear_n is a pin, synchronised with three flops
`timescale 1ns/1ps
`include "pc_stack_defs.vh"
module prog_counter_paging_stack #(
  parameter IP_WIDTH = `IP_WIDTH_DEFAULT
) (
  input  wire                        sys_clk,
  input  wire                        rst,
  input  wire                        master_clear_n,
  input  wire [2:0]                  op,
  input  wire [8:0]                  jump_target,
  input  wire [`LITERAL_WIDTH-1:0]   literal,
  input  wire [`PAGE_BITS_WIDTH-1:0] page_select_wdata,
  output reg  [IP_WIDTH-1:0]         instr_pointer,
  output wire [`LOW_BYTE_WIDTH-1:0]  instr_pointer_low_byte,
  output reg  [`PAGE_BITS_WIDTH-1:0] page_select_bits,
  output reg  [`LITERAL_WIDTH-1:0]   accumulator,
  output reg                         in_reset
);
  localparam [IP_WIDTH-1:0] RESET_VECTOR = {IP_WIDTH{1'b1}};
  localparam ST_RUN = 1'b0;
  localparam ST_RST = 1'b1;

  reg  [2:0]          master_clear_n_sync_reg;
  wire                clear_now;
  reg                 state_reg;
  wire [IP_WIDTH-1:0] stack_top;
  wire [IP_WIDTH-1:0] ip_plus_one;
  reg  [IP_WIDTH-1:0] ip_next;
  reg  [IP_WIDTH-1:0] paged_target;
  reg  [10:0]         wide_target;
  reg  [10:0]         wide_low;
  reg                 push;
  reg                 pop;

  assign instr_pointer_low_byte = instr_pointer[`LOW_BYTE_WIDTH-1:0];
  assign ip_plus_one = instr_pointer + {{(IP_WIDTH-1){1'b0}}, 1'b1};

  // Pin sync: act once the two later stages agree low
  always @(posedge sys_clk or posedge rst) begin
    if (rst)
      master_clear_n_sync_reg <= 3'h0;
    else
      master_clear_n_sync_reg <= {master_clear_n_sync_reg[1:0], master_clear_n};
  end
  assign clear_now = ~master_clear_n_sync_reg[1] & ~master_clear_n_sync_reg[2];

  always @(posedge sys_clk or posedge rst) begin
    if (rst)
      state_reg <= ST_RST;
    else if (clear_now)
      state_reg <= ST_RST;
    else
      state_reg <= ST_RUN;
  end

  always @* begin
    // Page bits land above bit 8; excess truncated away by width
    wide_target = {page_select_bits, jump_target};
    wide_low = {page_select_bits, 1'b0, literal};
    paged_target = RESET_VECTOR;
    if (op == `OP_WRITE_LOW)
      paged_target = wide_low[IP_WIDTH-1:0];
    else
      paged_target = wide_target[IP_WIDTH-1:0];
  end

  always @* begin
    push = 1'b0;
    pop = 1'b0;
    ip_next = instr_pointer;
    case (op)
      `OP_STEP, `OP_WRITE_PAGE:
        ip_next = ip_plus_one;
      `OP_GOTO, `OP_WRITE_LOW:
        ip_next = paged_target;
      `OP_CALL: begin
        // Blocked on the first clear cycle too, or the stack shifts in reset
        push = (state_reg == ST_RUN) && !clear_now;
        ip_next = paged_target;
      end
      `OP_RETURN_LIT: begin
        pop = (state_reg == ST_RUN) && !clear_now;
        ip_next = stack_top;
      end
      default:
        ip_next = instr_pointer;
    endcase
  end

  ret_stack #(
    .W(IP_WIDTH)
  ) u_stack (
    .sys_clk      (sys_clk),
    .rst          (rst),
    .push         (push),
    .pop          (pop),
    .push_addr    (ip_plus_one),
    .stack_top    (stack_top),
    .stack_level2 ()
  );

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      instr_pointer <= RESET_VECTOR;
      page_select_bits <= `PAGE_BITS_RESET;
      accumulator <= `ACC_RESET;
      in_reset <= 1'b1;
    end else if (clear_now || state_reg == ST_RST) begin
      instr_pointer <= RESET_VECTOR;
      page_select_bits <= `PAGE_BITS_RESET;
      in_reset <= clear_now;
    end else begin
      in_reset <= 1'b0;
      instr_pointer <= ip_next;
      if (op == `OP_WRITE_PAGE)
        page_select_bits <= page_select_wdata;
      if (op == `OP_RETURN_LIT)
        accumulator <= literal;
    end
  end
endmodule

/* src/pc_stack_defs.vh */
// Purpose: constants for the program sequencing block
// Assumes: included by bare name from the design files
// Notes on behaviour
// - Instruction pointer width is a parameter: 9, 10 or 11 bits.
// - Addresses above the configured width are discarded, so values wrap.
// - Reset loads the pointer with all ones, the last word of memory.
// - Incrementing from the reset vector rolls over to address zero.
// - Reset clears the page select bits, preselecting page zero.
// - Sequential increment carries into next page; page select bits stay unchanged.
// - Jump, call and low-byte write take upper bits from page select bits.
// - Two-level return stack, entries as wide as the pointer.
// - Call copies level one into two, then pointer plus one into one.
// - Beyond two calls only the two newest addresses remain, silently.
// - Return-with-literal loads pointer from stack top, copies two into one.
// - Return-with-literal also loads the accumulator with its 8-bit literal.
// - Further returns reload the old level-two address; pops never clear it.
`ifndef PC_STACK_DEFS_VH
`define PC_STACK_DEFS_VH
`define IP_WIDTH_DEFAULT    11
`define PAGE_BITS_WIDTH     2
`define PAGE_BITS_RESET     2'h0
`define LOW_BYTE_WIDTH      8
`define LITERAL_WIDTH       8
`define ACC_RESET           8'h00
`define PAGE_SIZE_LOG2      9
`define OP_NONE             3'h0
`define OP_STEP             3'h1
`define OP_GOTO             3'h2
`define OP_CALL             3'h3
`define OP_RETURN_LIT       3'h4
`define OP_WRITE_LOW        3'h5
`define OP_WRITE_PAGE       3'h6
`endif

/* src/ret_stack.v */
// Purpose: two-level return-address stack
// Assumes: push and pop never asserted together
// Notes: overflow and underflow raise no flag
`timescale 1ns/1ps
module ret_stack #(
  parameter W = 11
) (
  input  wire         sys_clk,
  input  wire         rst,
  input  wire         push,
  input  wire         pop,
  input  wire [W-1:0] push_addr,
  output wire [W-1:0] stack_top,
  output wire [W-1:0] stack_level2
);
  reg [W-1:0] level_reg [0:1];

  assign stack_top    = level_reg[0];
  assign stack_level2 = level_reg[1];

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      level_reg[0] <= {W{1'b0}};
      level_reg[1] <= {W{1'b0}};
    end else if (push) begin
      level_reg[1] <= level_reg[0];
      level_reg[0] <= push_addr;
      // Oldest entry falls off the end unreported
    end else if (pop) begin
      level_reg[0] <= level_reg[1];
      // Level two left as is, so repeated pops replay it
    end
  end
endmodule

/* dv/pcs_props.sv */
// Purpose: port checks for the sequencer
// Assumes: ops taken while in_reset low
// Notes: targets truncated to IP_WIDTH
`timescale 1ns/1ps
module pcs_props #(parameter IP_WIDTH = 11) (
  input wire                sys_clk,
  input wire                rst,
  input wire                master_clear_n,
  input wire [2:0]          op,
  input wire [8:0]          jump_target,
  input wire [7:0]          literal,
  input wire [IP_WIDTH-1:0] instr_pointer,
  input wire [1:0]          page_select_bits,
  input wire [7:0]          accumulator,
  input wire                in_reset
);
  wire [10:0]         tgt_full = {page_select_bits, jump_target};
  wire [10:0]         lowt_full = {page_select_bits, 1'b0, literal};
  wire [IP_WIDTH-1:0] tgt = tgt_full[IP_WIDTH-1:0];
  wire [IP_WIDTH-1:0] lowt = lowt_full[IP_WIDTH-1:0];
  wire                go = !in_reset;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  step_wrap_a: assert property (go && op == 3'h1 |=>
    instr_pointer == $past(instr_pointer) + 1'b1) else $error("step bad");
  page_keep_a: assert property (go && op == 3'h1 |=> $stable(page_select_bits))
    else $error("page bits moved");
  goto_page_a: assert property (go && op == 3'h2 |=> instr_pointer == $past(tgt))
    else $error("goto bad");
  low_write_a: assert property (go && op == 3'h5 |=> instr_pointer == $past(lowt))
    else $error("low write bad");
  ret_acc_a: assert property (go && op == 3'h4 |=> accumulator == $past(literal))
    else $error("acc bad");
  call_ret_a: assert property (go && op == 3'h3 ##1 op == 3'h4 |=>
    instr_pointer == $past(instr_pointer, 2) + 1'b1) else $error("return bad");
  reset_vec_a: assert property ($fell(in_reset) |->
    instr_pointer == {IP_WIDTH{1'b1}} && page_select_bits == 2'h0) else $error("vector bad");
  clear_in_a: assert property ($fell(master_clear_n) |-> ##[1:5] in_reset)
    else $error("clear ignored");
  cover property (go && op == 3'h3 ##1 op == 3'h4);
  cover property (go && op == 3'h1 && instr_pointer == {IP_WIDTH{1'b1}});
  cover property ($fell(master_clear_n));
endmodule
bind prog_counter_paging_stack pcs_props #(.IP_WIDTH(IP_WIDTH)) props_i (.sys_clk, .rst,
  .master_clear_n, .op, .jump_target, .literal, .instr_pointer, .page_select_bits,
  .accumulator, .in_reset);

/* dv/prog_mem.sv */
// Purpose: program memory partner
// Assumes: combinational read of 12-bit words
// Notes: contents are a fixed address pattern
`timescale 1ns/1ps
module prog_mem #(parameter W = 10) (
  input  wire [W-1:0] addr,
  output wire [11:0]  word
);
  assign word = {addr[3:0], addr[7:0]} ^ 12'h5a3;
endmodule

/* dv/prog_counter_paging_stack_tb.sv */
// Purpose: random and corner ops against a reference model
// Assumes: literal comes from the memory word at the pointer
// Notes: width 10 so the top page bit is ignored
`timescale 1ns/1ps
module prog_counter_paging_stack_tb;
  localparam W = 10;
  reg         sys_clk = 1'b0;
  reg         rst = 1'b1;
  reg         master_clear_n = 1'b1;
  reg  [2:0]  op = 3'h0;
  reg  [8:0]  tgt = 9'h000;
  reg  [1:0]  pw = 2'h0;
  wire [11:0] word;
  wire [W-1:0] ip;
  wire [7:0]  lb, acc;
  wire [1:0]  pa;
  wire        inr;
  reg  [W-1:0] m_ip;
  reg  [W-1:0] s1 = {W{1'b0}};
  reg  [W-1:0] s2 = {W{1'b0}};
  reg  [7:0]  m_acc;
  reg  [1:0]  m_pa;
  integer     n_fail = 0, n_tests = 0, cyc = 0, i;
  prog_counter_paging_stack #(.IP_WIDTH(W)) uut (.sys_clk(sys_clk), .rst(rst),
    .master_clear_n(master_clear_n), .op(op), .jump_target(tgt), .literal(word[7:0]),
    .page_select_wdata(pw), .instr_pointer(ip), .instr_pointer_low_byte(lb),
    .page_select_bits(pa), .accumulator(acc), .in_reset(inr));
  prog_mem #(.W(W)) mem (.addr(ip), .word(word));
  initial forever #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail = n_fail + 1;
      end_of_test;
    end
  end
  task check(input [15:0] seen, input [15:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task run_entry;
    begin
      m_ip = {W{1'b1}}; m_pa = 2'h0; m_acc = 8'h00;
      while (inr !== 1'b0) @(posedge sys_clk);
      @(posedge sys_clk);
      #1;
    end
  endtask
  task issue(input [2:0] o, input [8:0] t, input [1:0] p);
    reg [7:0] l;
    begin
      op = o; tgt = t; pw = p; l = word[7:0];
      @(posedge sys_clk);
      #1;
      case (o)
        3'h1: m_ip = m_ip + 1'b1;
        3'h6: begin m_ip = m_ip + 1'b1; m_pa = p; end
        3'h2: m_ip = {m_pa, t};
        3'h3: begin s2 = s1; s1 = m_ip + 1'b1; m_ip = {m_pa, t}; end
        3'h4: begin m_ip = s1; s1 = s2; m_acc = l; end
        3'h5: m_ip = {m_pa, 1'b0, l};
        default: ;
      endcase
      check(ip, m_ip);
      check(pa, m_pa);
      check(acc, m_acc);
      check(lb, m_ip[7:0]);
    end
  endtask
  task end_of_test;
    begin
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    i = $urandom(37);
    repeat (20) @(posedge sys_clk);
    #1 rst = 1'b0;
    run_entry;
    issue(3'h1, 9'h000, 2'h0);
    issue(3'h6, 9'h000, 2'h0);
    issue(3'h2, 9'h1ff, 2'h0);
    issue(3'h1, 9'h000, 2'h0);
    issue(3'h2, 9'h005, 2'h0);
    for (i = 0; i < 3; i = i + 1) issue(3'h3, $urandom, 2'h0);
    for (i = 0; i < 3; i = i + 1) issue(3'h4, 9'h000, 2'h0);
    for (i = 0; i < 400; i = i + 1) issue($urandom % 7, $urandom, $urandom);
    op = 3'h0;
    master_clear_n = 1'b0;
    repeat (6) @(posedge sys_clk);
    #1 master_clear_n = 1'b1;
    run_entry;
    for (i = 0; i < 40; i = i + 1) issue($urandom % 7, $urandom, $urandom);
    end_of_test;
  end
endmodule
